// ---- rtl/clkop_pkg.sv ----
// Purpose: constants for the core clock output and pll strap block
// Assumes: 32-bit apb, 250 MHz system clock
// Notes:   multiply and divide fields of zero act as one
package clkop_pkg;
  localparam int          CLKOP_CLK_MHZ      = 250;
  localparam int          CLKOP_OUT_MAX_MHZ  = 100;
  // least half period that keeps the output usable, rounded up to cycles
  localparam int          CLKOP_MIN_HALF_CYC =
    (CLKOP_CLK_MHZ + 2 * CLKOP_OUT_MAX_MHZ - 1) / (2 * CLKOP_OUT_MAX_MHZ);
  localparam logic [7:0]  CLKOP_PLL_CTL_OFS  = 8'h00;
  localparam logic [7:0]  CLKOP_OP_MODE_OFS  = 8'h04;
  localparam logic [7:0]  CLKOP_STATUS_OFS   = 8'h08;
  localparam int          CLKOP_PEN_BIT      = 0;
  localparam int          CLKOP_MUL_LSB      = 4;
  localparam int          CLKOP_MUL_W        = 12;
  localparam int          CLKOP_DIV_LSB      = 16;
  localparam int          CLKOP_DIV_W        = 4;
  localparam int          CLKOP_ABE_BIT      = 0;
  localparam int          CLKOP_ST_NMI_BIT   = 0;
  localparam int          CLKOP_ST_USE_BIT   = 1;
  localparam int          CLKOP_ST_LVL_BIT   = 2;
  localparam int          CLKOP_ST_PEN_BIT   = 3;
  localparam int          CLKOP_ST_PER_LSB   = 16;
  localparam int          CLKOP_PER_W        = 16;
  localparam logic [11:0] CLKOP_MUL_RST      = 12'h001;
  localparam logic [3:0]  CLKOP_DIV_RST      = 4'h1;
  localparam int          CLKOP_SYNC_W       = 4;
endpackage

// ---- rtl/clkop_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module clkop_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        meta_q[g] <= d_i[g];
        q_o[g]    <= meta_q[g];
      end
    end
  endgenerate
  // rstn_i and rst_val_i kept for a uniform port list; stages settle by themselves
  logic unused_w;
  assign unused_w = rstn_i ^ (|rst_val_i);
endmodule

// ---- rtl/clkop_top.sv ----
// Purpose: core clock output generation, pll strap capture, nmi edge request,
//          asynchronous arbitration mode, apb register access
// Assumes: clk_i is the core time base; pins are synchronised first
// Notes:   one wait state on every apb access
// Overview of operation
// - clock output phase-aligned to core clock ticks
// - unity pll factors keep output locked to crystal
// - pll off: output is half crystal rate
// - during reset strap sets pll on bit
// - falling nmi edge requests, aligned to output
// - async arbitration bit frees busy/grant from output
`timescale 1ns/1ps
module clkop_top
  import clkop_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        crystal_clock_in_i,
  input  wire logic        pll_strap_in_i,
  input  wire logic        nmi_n_i,
  input  wire logic        bus_busy_n_i,
  input  wire logic        bus_grant_n_i,
  output logic             crystal_drive_out_o,
  output logic             core_clock_out_o,
  output logic             core_clock_usable_o,
  output logic             nmi_req_o,
  output logic             async_arbitration_on_o,
  output logic             bus_busy_seen_o,
  output logic             bus_grant_seen_o
);
  logic [CLKOP_SYNC_W-1:0] pin_s;
  logic                    crystal_drive_out_s;
  logic                    strap_s;
  logic                    nmi_s;
  logic                    bb_s;
  logic                    bg_s;
  logic                    crystal_drive_out_d1_q;
  logic                    nmi_d1_q;
  logic                    crystal_drive_out_rise;
  logic                    nmi_fall;
  logic                    pll_on_bit_q;
  logic [CLKOP_MUL_W-1:0]  pll_mul_q;
  logic [CLKOP_DIV_W-1:0]  pll_div_q;
  logic [CLKOP_MUL_W-1:0]  mul_eff;
  logic [CLKOP_DIV_W-1:0]  div_eff;
  logic                    async_arb_q;
  logic                    nmi_pend_q;
  logic [CLKOP_PER_W-1:0]  per_cnt_q;
  logic [CLKOP_PER_W-1:0]  period_q;
  logic [23:0]             acc_q;
  logic [23:0]             thresh;
  logic                    unity;
  logic                    nco_tick;
  logic                    core_rise;
  logic                    out_d;
  logic [23:0]             acc_d;
  logic [7:0]              div_nz;
  logic [CLKOP_PER_W-1:0]  half_cnt_q;
  logic                    wr_go;
  logic                    rd_go;
  logic                    acc_ok;

  clkop_sync #(
    .W(CLKOP_SYNC_W)
  ) u_sync (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .d_i       ({bus_grant_n_i, bus_busy_n_i, nmi_n_i, crystal_clock_in_i}),
    .rst_val_i ({CLKOP_SYNC_W{1'b1}}),
    .q_o       (pin_s)
  );
  assign crystal_drive_out_s = pin_s[0];
  assign nmi_s  = pin_s[1];
  assign bb_s   = pin_s[2];
  assign bg_s   = pin_s[3];

  clkop_sync #(
    .W(1)
  ) u_strap (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .d_i       (pll_strap_in_i),
    .rst_val_i (1'b0),
    .q_o       (strap_s)
  );

  function automatic logic [7:0] nz_one(input logic [7:0] v);
    nz_one = (v == 8'h00) ? 8'h01 : v;
  endfunction

  assign mul_eff   = (pll_mul_q == '0) ? CLKOP_MUL_RST : pll_mul_q;
  assign div_nz    = nz_one({4'h0, pll_div_q});
  assign div_eff   = div_nz[CLKOP_DIV_W-1:0];
  assign unity     = (mul_eff == 12'h001) && (div_eff == 4'h1);
  assign crystal_drive_out_rise = crystal_drive_out_s & ~crystal_drive_out_d1_q;
  assign nmi_fall  = ~nmi_s & nmi_d1_q;
  assign thresh    = 24'(period_q * div_eff);
  assign nco_tick  = (thresh != 24'h0) && (acc_q >= thresh);
  // any rise of the output, whichever mode produces it
  assign core_rise = rstn_i & out_d & ~core_clock_out_o;

  always_ff @(posedge clk_i) begin
    crystal_drive_out_d1_q           <= crystal_drive_out_s;
    nmi_d1_q            <= nmi_s;
    crystal_drive_out_o <= ~crystal_drive_out_s;
  end

  // crystal period in system clocks, refreshed at each crystal rise
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      per_cnt_q <= '0;
      period_q  <= '0;
    end else if (crystal_drive_out_rise) begin
      per_cnt_q <= 16'h0001;
      period_q  <= per_cnt_q;
    end else if (per_cnt_q != 16'hffff) begin
      per_cnt_q <= per_cnt_q + 16'h0001;
    end
  end

  // output clock generator; each toggle is one core half period
  always_comb begin
    acc_d = acc_q + 24'({mul_eff, 1'b0});
    out_d = core_clock_out_o;
    if (!pll_on_bit_q) begin
      acc_d = '0;
      if (crystal_drive_out_rise) begin
        out_d = ~core_clock_out_o;
      end
    end else if (unity && crystal_drive_out_rise) begin
      acc_d = '0;
      out_d = 1'b1;
    end else if (nco_tick) begin
      acc_d = acc_q - thresh + 24'({mul_eff, 1'b0});
      out_d = ~core_clock_out_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      acc_q            <= '0;
      core_clock_out_o <= 1'b0;
    end else begin
      acc_q            <= acc_d;
      core_clock_out_o <= out_d;
    end
  end

  // usable only while every half period spans enough system clocks
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      half_cnt_q          <= '0;
      core_clock_usable_o <= 1'b0;
    end else if (out_d != core_clock_out_o) begin
      half_cnt_q          <= 16'h0001;
      core_clock_usable_o <= (half_cnt_q >= 16'(CLKOP_MIN_HALF_CYC));
    end else if (half_cnt_q != 16'hffff) begin
      half_cnt_q <= half_cnt_q + 16'h0001;
    end
  end

  // strap decides the pll enable while reset is held
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pll_on_bit_q <= strap_s;
      pll_mul_q    <= CLKOP_MUL_RST;
      pll_div_q    <= CLKOP_DIV_RST;
    end else if (wr_go && paddr_i == CLKOP_PLL_CTL_OFS) begin
      pll_on_bit_q <= pwdata_i[CLKOP_PEN_BIT];
      pll_mul_q    <= pwdata_i[CLKOP_MUL_LSB +: CLKOP_MUL_W];
      pll_div_q    <= pwdata_i[CLKOP_DIV_LSB +: CLKOP_DIV_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      async_arb_q <= 1'b0;
    end else if (wr_go && paddr_i == CLKOP_OP_MODE_OFS) begin
      async_arb_q <= pwdata_i[CLKOP_ABE_BIT];
    end
  end

  // nmi edge is held, then released on the next output rising edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nmi_pend_q <= 1'b0;
      nmi_req_o  <= 1'b0;
    end else begin
      nmi_req_o <= 1'b0;
      if (nmi_fall) begin
        nmi_pend_q <= 1'b1;
      end else if (nmi_pend_q && core_rise) begin
        nmi_pend_q <= 1'b0;
        nmi_req_o  <= 1'b1;
      end
    end
  end

  // busy/grant sampled at output rises unless asynchronous arbitration is on
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      async_arbitration_on_o <= 1'b0;
      bus_busy_seen_o        <= 1'b0;
      bus_grant_seen_o       <= 1'b0;
    end else begin
      async_arbitration_on_o <= async_arb_q;
      if (async_arb_q || core_rise) begin
        bus_busy_seen_o  <= ~bb_s;
        bus_grant_seen_o <= ~bg_s;
      end
    end
  end

  assign wr_go  = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_go  = psel_i & penable_i & ~pready_o & ~pwrite_i;
  assign acc_ok = (paddr_i == CLKOP_PLL_CTL_OFS) || (paddr_i == CLKOP_OP_MODE_OFS) ||
                  (paddr_i == CLKOP_STATUS_OFS);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~acc_ok;
      prdata_o  <= '0;
      if (rd_go) begin
        case (paddr_i)
          CLKOP_PLL_CTL_OFS: begin
            prdata_o[CLKOP_PEN_BIT]                  <= pll_on_bit_q;
            prdata_o[CLKOP_MUL_LSB +: CLKOP_MUL_W]   <= pll_mul_q;
            prdata_o[CLKOP_DIV_LSB +: CLKOP_DIV_W]   <= pll_div_q;
          end
          CLKOP_OP_MODE_OFS: begin
            prdata_o[CLKOP_ABE_BIT] <= async_arb_q;
          end
          CLKOP_STATUS_OFS: begin
            prdata_o[CLKOP_ST_NMI_BIT]                <= nmi_pend_q;
            prdata_o[CLKOP_ST_USE_BIT]                <= core_clock_usable_o;
            prdata_o[CLKOP_ST_LVL_BIT]                <= core_clock_out_o;
            prdata_o[CLKOP_ST_PEN_BIT]                <= pll_on_bit_q;
            prdata_o[CLKOP_ST_PER_LSB +: CLKOP_PER_W] <= period_q;
          end
          default: begin
            prdata_o <= '0;
          end
        endcase
      end
    end
  end
endmodule

// ---- verification/clkop_checker.sv ----
// Purpose: port timing checks
// Assumes: one clock domain
// Notes:   bound from the bench
`timescale 1ns/1ps
module clkop_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        core_clock_out_o,
  input wire logic        nmi_req_o,
  input wire logic        async_arbitration_on_o,
  input wire logic        bus_busy_seen_o,
  input wire logic        bus_grant_seen_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_ANS: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
    else $error("no answer after one wait state");
  AST_RDY: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
    else $error("ready outside an access");
  AST_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_ERR: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_RDZ: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  AST_NMI: assert property (nmi_req_o |-> $rose(core_clock_out_o))
    else $error("request not on output rise");
  AST_BUSY: assert property ($changed(bus_busy_seen_o) && !async_arbitration_on_o
    && !$past(async_arbitration_on_o) |-> $rose(core_clock_out_o))
    else $error("busy sampled off output rise");
  AST_GRANT: assert property ($changed(bus_grant_seen_o) && !async_arbitration_on_o
    && !$past(async_arbitration_on_o) |-> $rose(core_clock_out_o))
    else $error("grant sampled off output rise");
  AST_RST: assert property (@(posedge clk_i) disable iff (1'b0)
    !rstn_i |=> !pready_o && !nmi_req_o && !core_clock_out_o)
    else $error("outputs active in reset");
endmodule

// ---- verification/clkop_board.sv ----
// Purpose: crystal source model
// Assumes: stepped on the bench clock
// Notes:   runs free, half period in clk cycles
`timescale 1ns/1ps
module clkop_board (
  input  wire logic       clk_i,
  input  wire logic [7:0] half_i,
  output logic            crystal_o
);
  logic [7:0] cnt_q;
  initial begin
    crystal_o = 1'b0;
    cnt_q     = 8'h00;
  end
  always @(posedge clk_i) begin
    if (cnt_q + 8'h01 >= half_i) begin
      cnt_q     <= 8'h00;
      crystal_o <= ~crystal_o;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ---- verification/clkop_top_bench.sv ----
// Purpose: self-checking bench for clkop_top
// Assumes: 250 MHz clock, crystal period 8 clk
// Notes:   apb waits on pready
`timescale 1ns/1ps
module clkop_top_bench import clkop_pkg::*;;
  logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, er;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, crystal_clock_in_i, pll_strap_in_i, nmi_n_i;
  logic        bus_busy_n_i, bus_grant_n_i, crystal_drive_out_o, core_clock_out_o;
  logic        core_clock_usable_o, nmi_req_o, async_arbitration_on_o;
  logic        bus_busy_seen_o, bus_grant_seen_o;
  int          err_total, samples_checked, p;
  logic [2:0]  xh;
  logic [11:0] mul_t [4] = '{12'h1, 12'h2, 12'h1, 12'h4};
  logic [3:0]  div_t [4] = '{4'h1, 4'h1, 4'h2, 4'h1};
  int          per_t [4] = '{8, 4, 16, 2};
  clkop_board i_board (.clk_i, .half_i(8'h04), .crystal_o(crystal_clock_in_i));
  clkop_top i_dut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .crystal_clock_in_i, .pll_strap_in_i, .nmi_n_i,
    .bus_busy_n_i, .bus_grant_n_i, .crystal_drive_out_o, .core_clock_out_o,
    .core_clock_usable_o, .nmi_req_o, .async_arbitration_on_o, .bus_busy_seen_o,
    .bus_grant_seen_o);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    while (pready_o !== 1'b1) @(negedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    @(posedge clk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rst(input logic s);
    rstn_i         <= 1'b0;
    pll_strap_in_i <= s;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // period of the clock output in clk cycles, second full period
  task automatic per;
    time t;
    repeat (2) @(posedge core_clock_out_o);
    t = $time;
    @(posedge core_clock_out_o);
    p = int'(($time - t) / 4);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // crystal pin delayed by the synchroniser and output register depth
  always @(posedge clk_i) xh <= {xh[1:0], crystal_clock_in_i};
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run;
  end
  initial begin
    {psel_i, penable_i, pwrite_i, nmi_n_i, bus_busy_n_i, bus_grant_n_i} = 6'b000111;
    paddr_i  = 8'h00;
    pwdata_i = 32'h0;
    rst(1'b0);
    apb(1'b0, CLKOP_PLL_CTL_OFS, 32'h0);
    chk(rd, 32'h0001_0010);
    apb(1'b0, CLKOP_STATUS_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    per;
    chk(p, 32'h10);
    bus_grant_n_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk({31'h0, bus_grant_seen_o}, 32'h1);
    nmi_n_i <= 1'b0;
    do @(negedge clk_i); while (nmi_req_o !== 1'b1);
    chk({31'h0, core_clock_out_o}, 32'h1);
    @(posedge clk_i);
    nmi_n_i <= 1'b1;
    repeat (8) begin
      @(negedge clk_i);
      chk({31'h0, crystal_drive_out_o}, {31'h0, ~xh[2]});
    end
    @(posedge clk_i);
    $display("test pll off done");
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    $display("test unmapped done");
    apb(1'b1, CLKOP_OP_MODE_OFS, 32'h1);
    apb(1'b0, CLKOP_OP_MODE_OFS, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, async_arbitration_on_o}, 32'h1);
    bus_busy_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({31'h0, bus_busy_seen_o}, 32'h1);
    $display("test async done");
    rst(1'b1);
    apb(1'b0, CLKOP_PLL_CTL_OFS, 32'h0);
    chk(rd, 32'h0001_0011);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CLKOP_PLL_CTL_OFS, {12'h0, div_t[i], mul_t[i], 4'h1});
      apb(1'b0, CLKOP_PLL_CTL_OFS, 32'h0);
      chk(rd, {12'h0, div_t[i], mul_t[i], 4'h1});
      per;
      chk(p, per_t[i]);
      chk({31'h0, core_clock_usable_o}, {31'h0, per_t[i] >= 4});
    end
    $display("test pll on done");
    complete_run;
  end
endmodule
bind clkop_top clkop_checker i_chk (.clk_i, .rstn_i, .psel_i, .penable_i, .prdata_o,
  .pready_o, .pslverr_o, .core_clock_out_o, .nmi_req_o, .async_arbitration_on_o,
  .bus_busy_seen_o, .bus_grant_seen_o);
